// ---- design/ioxirq_pkg.sv ----
// Purpose: shared constants and types for the 16-bit serial I/O expander core
// Assumes: 200 MHz core clock; serial link sampled, not used as a clock
// Notes:   register codes follow the command pointer layout (pair in bits 2:1)
`default_nettype none
package ioxirq_pkg;
  // core clock and interrupt timing
  localparam int CLK_PERIOD_NS       = 5;
  localparam int IRQ_VALID_DELAY_NS  = 4000;
  // longest time, so integer division rounds down
  localparam int IRQ_VALID_DELAY_CYC = IRQ_VALID_DELAY_NS / CLK_PERIOD_NS;
  localparam int IRQ_CNT_W           = 10;
  // slave address: fixed upper nibble then the three select pins
  localparam logic [3:0] ADDR_FIXED  = 4'h4;
  // register pair codes (command pointer bits 2:1)
  localparam logic [1:0] PAIR_IN     = 2'h0;
  localparam logic [1:0] PAIR_OUT    = 2'h1;
  localparam logic [1:0] PAIR_POL    = 2'h2;
  localparam logic [1:0] PAIR_CFG    = 2'h3;
  // values after reset
  localparam logic [15:0] RST_OUT    = 16'hFFFF;
  localparam logic [15:0] RST_POL    = 16'h0000;
  localparam logic [15:0] RST_CFG    = 16'hFFFF;
  localparam logic [2:0]  RST_PTR    = 3'h0;
  // bit counts on the serial link
  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_TX_BIT = 4'h7;
  // byte position inside a transfer
  localparam logic [1:0] IDX_ADDR    = 2'h0;
  localparam logic [1:0] IDX_CMD     = 2'h1;
  localparam logic [1:0] IDX_DATA    = 2'h2;

  // serial slave states, gray along idle-rx-ack-tx-ack
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RX   = 3'h1,
    ST_RACK = 3'h3,
    ST_TX   = 3'h2,
    ST_TACK = 3'h6,
    ST_SKIP = 3'h4
  } ioxirq_state_t;

  // port pin drive bundle
  typedef struct packed {
    logic [15:0] hi;  // high-side driver enables
    logic [15:0] lo;  // low-side driver enables
    logic [15:0] oe;  // pin output enable
    logic [15:0] dat; // pin output level
  } ioxirq_drv_t;
endpackage
`default_nettype wire

// ---- design/ioxirq_top.sv ----
// Purpose: 16-bit serial-controlled I/O expander with change interrupt
// Assumes: SCL/SDA/pins come from outside and are synchronised here
// Notes:   serial clock is oversampled; the core never runs on it
//
// Summary of operation
// - reset puts registers and slave in defaults
// - input pins have both drivers off
// - output pins drive exactly one side per latch
// - input edges raise interrupt after valid delay
// - interrupt drops when input returns to original
// - port read clears interrupt at ack rise
// - every change after clearing is signalled again
// - foreign traffic, output pins never interrupt
// - output-to-input switch may raise interrupt
// - clearing tracked separately for each port
// - interrupt is open-drain, active low
// - pointer zero plus foreign read ack clears
// - general call address is never acknowledged
// - matching address acknowledged with SDA low
// - SDA moves with SCL low; else start/stop
// - eight bits then one ack bit each
// - slave receiver acknowledges every received byte
// - master NACK ends read; slave releases SDA
// - ack held low across whole SCL high
// - address is 0100 plus three select pins
// - first write byte sets the command pointer
// - pointer toggles within pair, persists across reads
// - input regs show pins; outputs, directions default high
`default_nettype none
module ioxirq_top (
  input  wire logic        REF_CLK_IN,
  input  wire logic        SRST_IN,
  input  wire logic        SCL_IN,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_OUT,
  input  wire logic [2:0]  ADDR_SEL_PINS_IN,
  input  wire logic [15:0] PORT_IN,
  output logic [15:0]      PORT_OUT,
  output logic [15:0]      PORT_OE_OUT,
  output logic [15:0]      HIGH_SIDE_DRIVER_OUT,
  output logic [15:0]      LOW_SIDE_DRIVER_OUT,
  output logic             IRQ_N_OUT,
  output logic             IRQ_N_OE_OUT
);
  // synchronisers: first stage read only by second stage
  logic [1:0]                 scl_meta_r, sda_meta_r, scl_hist_r, sda_hist_r;
  logic                       scl_f_r, sda_f_r, scl_d_r, sda_d_r;
  logic [15:0]                pin_meta_r, pin_s_r;
  logic [2:0]                 asel_meta_r, asel_s_r;
  // serial slave and register file
  ioxirq_pkg::ioxirq_state_t  state_r, state_nxt;
  logic [3:0]                 bitcnt_r, bitcnt_nxt;
  logic [7:0]                 sh_r, sh_nxt;
  logic [1:0]                 idx_r, idx_nxt;
  logic                       rw_r, rw_nxt;
  logic [2:0]                 ptr_r, ptr_nxt;
  logic [15:0]                out_r, out_nxt, pol_r, pol_nxt, cfg_r, cfg_nxt;
  logic                       sda_oe_r, sda_oe_nxt;
  logic [1:0]                 clr;
  logic [15:0]                sel16;
  logic [7:0]                 rd_byte;
  logic                       scl_rise, scl_fall, start_c, stop_c;
  // interrupt group
  logic [15:0]                snap_r, snap_nxt, chg;
  logic                       snap_ok_r, snap_ok_nxt, irq_r, irq_nxt;
  logic [ioxirq_pkg::IRQ_CNT_W-1:0] cnt_r, cnt_nxt;
  localparam logic [ioxirq_pkg::IRQ_CNT_W-1:0] DLY =
    ioxirq_pkg::IRQ_CNT_W'(ioxirq_pkg::IRQ_VALID_DELAY_CYC);
  // pin drive group
  ioxirq_pkg::ioxirq_drv_t    drv_r, drv_nxt;

  // input sync and 3-sample agreement filter rejects spikes under 10 ns
  always_ff @(posedge REF_CLK_IN) begin
    scl_meta_r  <= {scl_meta_r[0], SCL_IN};
    sda_meta_r  <= {sda_meta_r[0], SDA_IN};
    pin_meta_r  <= PORT_IN;
    pin_s_r     <= pin_meta_r;
    asel_meta_r <= ADDR_SEL_PINS_IN;
    asel_s_r    <= asel_meta_r;
    if (SRST_IN) begin
      scl_hist_r <= 2'h3;
      sda_hist_r <= 2'h3;
      scl_f_r    <= 1'b1;
      sda_f_r    <= 1'b1;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_hist_r <= {scl_hist_r[0], scl_meta_r[1]};
      sda_hist_r <= {sda_hist_r[0], sda_meta_r[1]};
      if (scl_hist_r[0] == scl_meta_r[1] && scl_hist_r[1] == scl_meta_r[1]) begin
        scl_f_r <= scl_meta_r[1];
      end
      if (sda_hist_r[0] == sda_meta_r[1] && sda_hist_r[1] == sda_meta_r[1]) begin
        sda_f_r <= sda_meta_r[1];
      end
      scl_d_r <= scl_f_r;
      sda_d_r <= sda_f_r;
    end
  end

  // link events: SDA moving while SCL high is start or stop
  assign scl_rise = scl_f_r & ~scl_d_r;
  assign scl_fall = ~scl_f_r & scl_d_r;
  assign start_c  = scl_f_r & scl_d_r & sda_d_r & ~sda_f_r;
  assign stop_c   = scl_f_r & scl_d_r & ~sda_d_r & sda_f_r;

  // read data: input register is pins with optional inversion
  always_comb begin
    case (ptr_r[2:1])
      ioxirq_pkg::PAIR_IN:  sel16 = pin_s_r ^ pol_r;
      ioxirq_pkg::PAIR_OUT: sel16 = out_r;
      ioxirq_pkg::PAIR_POL: sel16 = pol_r;
      default:              sel16 = cfg_r;
    endcase
    rd_byte = ptr_r[0] ? sel16[15:8] : sel16[7:0];
  end

  // serial slave next state
  always_comb begin
    state_nxt  = state_r;
    bitcnt_nxt = bitcnt_r;
    sh_nxt     = sh_r;
    idx_nxt    = idx_r;
    rw_nxt     = rw_r;
    ptr_nxt    = ptr_r;
    out_nxt    = out_r;
    pol_nxt    = pol_r;
    cfg_nxt    = cfg_r;
    sda_oe_nxt = sda_oe_r;
    clr        = 2'h0;
    if (start_c) begin
      state_nxt  = ioxirq_pkg::ST_RX;
      bitcnt_nxt = 4'h0;
      idx_nxt    = ioxirq_pkg::IDX_ADDR;
      sda_oe_nxt = 1'b0;
    end else if (stop_c) begin
      state_nxt  = ioxirq_pkg::ST_IDLE;
      sda_oe_nxt = 1'b0;
    end else begin
      case (state_r)
        ioxirq_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_nxt     = {sh_r[6:0], sda_f_r};
            bitcnt_nxt = bitcnt_r + 4'h1;
          end
          if (scl_fall && bitcnt_r == ioxirq_pkg::BYTE_BITS) begin
            bitcnt_nxt = 4'h0;
            if (idx_r == ioxirq_pkg::IDX_ADDR) begin
              rw_nxt = sh_r[0];
              // general call (all zero) never matches the fixed nibble
              if (sh_r[7:1] == {ioxirq_pkg::ADDR_FIXED, asel_s_r}) begin
                state_nxt  = ioxirq_pkg::ST_RACK;
                sda_oe_nxt = 1'b1;
                idx_nxt    = ioxirq_pkg::IDX_CMD;
              end else begin
                state_nxt = ioxirq_pkg::ST_SKIP;
              end
            end else begin
              state_nxt  = ioxirq_pkg::ST_RACK;
              sda_oe_nxt = 1'b1;
              idx_nxt    = ioxirq_pkg::IDX_DATA;
              if (idx_r == ioxirq_pkg::IDX_CMD) begin
                ptr_nxt = sh_r[2:0];
              end else begin
                case (ptr_r[2:1])
                  ioxirq_pkg::PAIR_OUT: if (ptr_r[0]) out_nxt[15:8] = sh_r;
                                        else out_nxt[7:0] = sh_r;
                  ioxirq_pkg::PAIR_POL: if (ptr_r[0]) pol_nxt[15:8] = sh_r;
                                        else pol_nxt[7:0] = sh_r;
                  ioxirq_pkg::PAIR_CFG: if (ptr_r[0]) cfg_nxt[15:8] = sh_r;
                                        else cfg_nxt[7:0] = sh_r;
                  default: ; // input pair ignores writes
                endcase
                ptr_nxt = {ptr_r[2:1], ~ptr_r[0]};
              end
            end
          end
        end
        ioxirq_pkg::ST_RACK: begin
          // ack held from one falling edge to the next covers SCL high
          if (scl_fall) begin
            bitcnt_nxt = 4'h0;
            if (rw_r) begin
              state_nxt  = ioxirq_pkg::ST_TX;
              sh_nxt     = rd_byte;
              sda_oe_nxt = ~rd_byte[7];
            end else begin
              state_nxt  = ioxirq_pkg::ST_RX;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        ioxirq_pkg::ST_TX: begin
          if (scl_fall) begin
            bitcnt_nxt = bitcnt_r + 4'h1;
            if (bitcnt_r == ioxirq_pkg::LAST_TX_BIT) begin
              state_nxt  = ioxirq_pkg::ST_TACK;
              sda_oe_nxt = 1'b0;
            end else begin
              sh_nxt     = {sh_r[6:0], 1'b0};
              sda_oe_nxt = ~sh_r[6];
            end
          end
        end
        ioxirq_pkg::ST_TACK: begin
          if (scl_rise) begin
            sh_nxt[0] = sda_f_r;
            ptr_nxt   = {ptr_r[2:1], ~ptr_r[0]};
            if (ptr_r[2:1] == ioxirq_pkg::PAIR_IN) begin
              clr[ptr_r[0]] = 1'b1;
            end
          end
          if (scl_fall) begin
            if (!sh_r[0]) begin
              state_nxt  = ioxirq_pkg::ST_TX;
              bitcnt_nxt = 4'h0;
              sh_nxt     = rd_byte;
              sda_oe_nxt = ~rd_byte[7];
            end else begin
              state_nxt  = ioxirq_pkg::ST_IDLE;
              sda_oe_nxt = 1'b0;
            end
          end
        end
        ioxirq_pkg::ST_SKIP: begin
          // replicated defect: another slave acking a read with pointer zero
          if (scl_rise) begin
            state_nxt = ioxirq_pkg::ST_IDLE;
            if (rw_r && !sda_f_r && ptr_r == 3'h0) begin
              clr = 2'h3;
            end
          end
        end
        ioxirq_pkg::ST_IDLE: ;
        default: state_nxt = ioxirq_pkg::ST_IDLE;
      endcase
    end
  end

  // serial slave registers
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      state_r  <= ioxirq_pkg::ST_IDLE;
      bitcnt_r <= 4'h0;
      sh_r     <= 8'h00;
      idx_r    <= ioxirq_pkg::IDX_ADDR;
      rw_r     <= 1'b0;
      ptr_r    <= ioxirq_pkg::RST_PTR;
      out_r    <= ioxirq_pkg::RST_OUT;
      pol_r    <= ioxirq_pkg::RST_POL;
      cfg_r    <= ioxirq_pkg::RST_CFG;
      sda_oe_r <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      bitcnt_r <= bitcnt_nxt;
      sh_r     <= sh_nxt;
      idx_r    <= idx_nxt;
      rw_r     <= rw_nxt;
      ptr_r    <= ptr_nxt;
      out_r    <= out_nxt;
      pol_r    <= pol_nxt;
      cfg_r    <= cfg_nxt;
      sda_oe_r <= sda_oe_nxt;
    end
  end

  // change detect: output pins are masked out by direction
  assign chg = (pin_s_r ^ snap_r) & cfg_r;

  // interrupt next state; snapshot caught on first cycle after reset
  always_comb begin
    snap_nxt    = snap_r;
    snap_ok_nxt = 1'b1;
    if (!snap_ok_r) begin
      snap_nxt = pin_s_r;
    end
    if (clr[0]) begin
      snap_nxt[7:0] = pin_s_r[7:0];
    end
    if (clr[1]) begin
      snap_nxt[15:8] = pin_s_r[15:8];
    end
    // counter restarts whenever no input differs from the snapshot, so later changes are seen again
    if (|chg) begin
      cnt_nxt = (cnt_r == DLY) ? cnt_r : cnt_r + 1'b1;
    end else begin
      cnt_nxt = '0;
    end
    irq_nxt = (|chg) && (cnt_r == DLY);
  end

  // interrupt registers
  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      snap_r    <= 16'h0000;
      snap_ok_r <= 1'b0;
      cnt_r     <= '0;
      irq_r     <= 1'b0;
    end else begin
      snap_r    <= snap_nxt;
      snap_ok_r <= snap_ok_nxt;
      cnt_r     <= cnt_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // pin drivers: one side per output pin, none for inputs
  always_comb begin
    drv_nxt.oe  = ~cfg_r;
    drv_nxt.dat = out_r;
    drv_nxt.hi  = ~cfg_r & out_r;
    drv_nxt.lo  = ~cfg_r & ~out_r;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SRST_IN) begin
      drv_r <= '0;
    end else begin
      drv_r <= drv_nxt;
    end
  end

  // outputs; both open-drain lines only ever pull low
  assign PORT_OUT             = drv_r.dat;
  assign PORT_OE_OUT          = drv_r.oe;
  assign HIGH_SIDE_DRIVER_OUT = drv_r.hi;
  assign LOW_SIDE_DRIVER_OUT  = drv_r.lo;
  assign SDA_OUT              = 1'b0;
  assign SDA_OE_OUT           = sda_oe_r;
  assign IRQ_N_OUT            = 1'b0;
  assign IRQ_N_OE_OUT         = irq_r;

  property p_reset_defaults;
    @(posedge REF_CLK_IN) $fell(SRST_IN) |-> (out_r == ioxirq_pkg::RST_OUT &&
      cfg_r == ioxirq_pkg::RST_CFG && pol_r == ioxirq_pkg::RST_POL && !irq_r);
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset defaults");
  property p_input_hiz;
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
      ##1 ((drv_r.hi | drv_r.lo | drv_r.oe) & $past(cfg_r)) == 16'h0000;
  endproperty
  a_input_hiz: assert property (p_input_hiz) else $error("input pin driven");
  property p_one_driver;
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
      ##1 (drv_r.hi == ($past(out_r) & ~$past(cfg_r)) && (drv_r.hi & drv_r.lo) == 16'h0000);
  endproperty
  a_one_driver: assert property (p_one_driver) else $error("wrong driver side");
  property p_irq_delay;
    @(posedge REF_CLK_IN) disable iff (SRST_IN) $rose(irq_r) |-> $past(cnt_r) == DLY;
  endproperty
  a_irq_delay: assert property (p_irq_delay) else $error("interrupt too early");
  property p_irq_drop;
    @(posedge REF_CLK_IN) disable iff (SRST_IN) (chg == 16'h0000) |=> !irq_r;
  endproperty
  a_irq_drop: assert property (p_irq_drop) else $error("interrupt stuck");
  property p_irq_pin;
    @(posedge REF_CLK_IN) disable iff (SRST_IN) irq_r |-> (IRQ_N_OE_OUT && !IRQ_N_OUT);
  endproperty
  a_irq_pin: assert property (p_irq_pin) else $error("interrupt not pulled low");
  property p_port_clear;
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
      (clr == 2'h1 && snap_ok_r) |=> (snap_r[15:8] == $past(snap_r[15:8]));
  endproperty
  a_port_clear: assert property (p_port_clear) else $error("other port cleared");
  property p_addr_ack;
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
      (state_r == ioxirq_pkg::ST_RACK && !start_c && !stop_c && scl_rise) |-> sda_oe_r;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("ack not driven");
  property p_no_gcall;
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
      (state_r == ioxirq_pkg::ST_RX && idx_r == ioxirq_pkg::IDX_ADDR && sh_r == 8'h00)
      |=> state_r != ioxirq_pkg::ST_RACK;
  endproperty
  a_no_gcall: assert property (p_no_gcall) else $error("general call acked");
  property p_ptr_toggle;
    @(posedge REF_CLK_IN) disable iff (SRST_IN)
      (state_r == ioxirq_pkg::ST_TACK && scl_rise && !start_c && !stop_c)
      |=> ptr_r == {$past(ptr_r[2:1]), ~$past(ptr_r[0])};
  endproperty
  a_ptr_toggle: assert property (p_ptr_toggle) else $error("pointer not toggled");
endmodule
`default_nettype wire

// ---- verif/ioxirq_i2c_master.sv ----
// Purpose: behavioural serial bus master that drives the expander's link
// Assumes: open-drain wires are resolved by the bench with pull-ups
// Notes:   one bit takes 25 core cycles, which matches the 125 ns link period
`default_nettype none
module ioxirq_i2c_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var logic  scl_low_out,
  output var logic  sda_low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // both lines released, so the idle bus reads high and the clock stands still
  initial begin
    scl_low_out = 1'b0;
    sda_low_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // start only from an idle bus: data falls while the clock is high
  task automatic start();
    tick(13);
    sda_low_out <= 1'b1;
    tick(13);
    scl_low_out <= 1'b1;
  endtask
  // stop: data rises while the clock is high, then the bus rests
  task automatic stop();
    tick(6);
    sda_low_out <= 1'b1;
    tick(7);
    scl_low_out <= 1'b0;
    tick(12);
    sda_low_out <= 1'b0;
    tick(13);
  endtask
  // data moves mid low phase only; sampled late in the high phase, past the filters
  task automatic bit_x(input logic b, output logic seen);
    tick(6);
    sda_low_out <= ~b;
    tick(7);
    scl_low_out <= 1'b0;
    tick(10);
    seen = sda_in;
    tick(2);
    scl_low_out <= 1'b1;
  endtask
  // eight bits msb first, then one ack bit; a released bit reads back the far side
  task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
                      output logic ack_seen);
    for (int i = 7; i >= 0; i--) begin
      bit_x(tx[i], rx[i]);
    end
    bit_x(ack_in, ack_seen);
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_ioxirq_top.sv ----
// Purpose: self-checking bench for the serial I/O expander core
// Assumes: the partner model is the only master; pull-ups on SDA and SCL
// Notes:   every register access rides on real frames, so a byte costs 225 cycles
`default_nettype none
module tb_ioxirq_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] DEV_ADDR = {ioxirq_pkg::ADDR_FIXED, 3'h5};
  typedef struct packed {
    logic [7:0]  cmd;
    logic [7:0]  d0;
    logic [7:0]  d1;
    logic [15:0] out;
    logic [15:0] oe;
  } ioxirq_row_t;
  // write two bytes to a pair, read them back, then check the pin drivers
  localparam ioxirq_row_t ROWS [4] = '{
    '{8'h02, 8'h55, 8'hAA, 16'hAA55, 16'h0000},
    '{8'h07, 8'h0F, 8'hF0, 16'hAA55, 16'hF00F},
    '{8'h03, 8'h00, 8'hFF, 16'h00FF, 16'hF00F},
    '{8'h04, 8'h01, 8'h80, 16'h00FF, 16'hF00F}};
  logic        ref_clk;
  logic        srst;
  logic [2:0]  addr_sel;
  logic [15:0] port_pins;
  logic        scl_low;
  logic        sda_low;
  logic        sda_o;
  logic        sda_oe;
  logic        irq_n;
  logic        irq_oe;
  logic [15:0] port_o;
  logic [15:0] port_oe;
  logic [15:0] hi_drv;
  logic [15:0] lo_drv;
  logic [7:0]  rx0;
  logic [7:0]  rx1;
  logic        ack;
  int          err_count = 0;
  int          checks_done = 0;
  // open-drain wires: low when any party pulls, pulled up otherwise
  wire logic   scl_wire = ~scl_low;
  wire logic   sda_wire = ~(sda_low | (sda_oe & ~sda_o));

  ioxirq_top ioxirq_top_inst (
    .REF_CLK_IN(ref_clk), .SRST_IN(srst), .SCL_IN(scl_wire), .SDA_IN(sda_wire),
    .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .ADDR_SEL_PINS_IN(addr_sel),
    .PORT_IN(port_pins), .PORT_OUT(port_o), .PORT_OE_OUT(port_oe),
    .HIGH_SIDE_DRIVER_OUT(hi_drv), .LOW_SIDE_DRIVER_OUT(lo_drv),
    .IRQ_N_OUT(irq_n), .IRQ_N_OE_OUT(irq_oe));
  ioxirq_i2c_master ioxirq_i2c_master_inst (
    .clk_in(ref_clk), .sda_in(sda_wire), .scl_low_out(scl_low), .sda_low_out(sda_low));

  // 200 MHz core clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d, comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic irq_at(input int n, input logic exp);
    tick(n);
    chk({15'h0, irq_oe}, {15'h0, exp});
  endtask
  // start and address byte; fgn makes the model play another slave that acks
  task automatic open_frame(input logic [6:0] a, input logic rw, input logic fgn);
    logic [7:0] unused;
    ioxirq_i2c_master_inst.start();
    ioxirq_i2c_master_inst.xfer({a, rw}, ~fgn, unused, ack);
  endtask
  // command byte plus n data bytes, every byte must be acked
  task automatic wr(input logic [7:0] cmd, input logic [7:0] d0, input logic [7:0] d1,
                    input int n);
    logic [7:0] unused;
    open_frame(DEV_ADDR, 1'b0, 1'b0);
    chk({15'h0, ack}, 16'h0000);
    for (int i = 0; i <= n; i++) begin
      ioxirq_i2c_master_inst.xfer(i == 0 ? cmd : (i == 1 ? d0 : d1), 1'b1, unused, ack);
      chk({15'h0, ack}, 16'h0000);
    end
    ioxirq_i2c_master_inst.stop();
  endtask
  // read n bytes (1 or 2) from the current pointer, nack on the last
  task automatic rd(input int n);
    open_frame(DEV_ADDR, 1'b1, 1'b0);
    chk({15'h0, ack}, 16'h0000);
    ioxirq_i2c_master_inst.xfer(8'hFF, n == 1, rx0, ack);
    if (n == 2) ioxirq_i2c_master_inst.xfer(8'hFF, 1'b1, rx1, ack);
    ioxirq_i2c_master_inst.stop();
  endtask

  // watchdog: the sequence needs about 20000 cycles
  initial begin
    tick(60000);
    err_count++;
    close_out();
  end

  initial begin
    srst      <= 1'b1;
    addr_sel  <= 3'h5;
    port_pins <= 16'h0000;
    tick(3);
    srst <= 1'b0;
    tick(20);
    chk(port_o, 16'hFFFF);
    chk(port_oe | hi_drv | lo_drv, 16'h0000);
    chk({14'h0, irq_oe, irq_n}, 16'h0000);
    // general call and a neighbour's address go unanswered
    open_frame(7'h00, 1'b0, 1'b0);
    chk({15'h0, ack}, 16'h0001);
    ioxirq_i2c_master_inst.stop();
    open_frame({ioxirq_pkg::ADDR_FIXED, 3'h4}, 1'b0, 1'b0);
    chk({15'h0, ack}, 16'h0001);
    ioxirq_i2c_master_inst.stop();
    foreach (ROWS[i]) begin
      wr(ROWS[i].cmd, ROWS[i].d0, ROWS[i].d1, 2);
      wr(ROWS[i].cmd, 8'h00, 8'h00, 0);
      rd(2);
      chk({rx1, rx0}, {ROWS[i].d1, ROWS[i].d0});
      chk(port_o, ROWS[i].out);
      chk(port_oe, ROWS[i].oe);
      chk(hi_drv, ROWS[i].oe & ROWS[i].out);
      chk(lo_drv, ROWS[i].oe & ~ROWS[i].out);
    end
    // writes to the input pair are acked but leave the pin view untouched
    wr(8'h01, 8'hA5, 8'h5A, 2);
    rd(1);
    chk({8'h00, rx0}, 16'h0080);
    // pins 7:4 and 11:8 are inputs now; an output pin must stay silent
    port_pins <= 16'h0001;
    irq_at(900, 1'b0);
    port_pins <= 16'h0011;
    irq_at(780, 1'b0);
    irq_at(50, 1'b1);
    port_pins <= 16'h0001;
    irq_at(10, 1'b0);
    port_pins <= 16'h0011;
    irq_at(830, 1'b1);
    // foreign write, a read of the quiet port and a bare pointer write keep it
    open_frame(7'h31, 1'b0, 1'b0);
    ioxirq_i2c_master_inst.stop();
    irq_at(2, 1'b1);
    wr(8'h01, 8'h00, 8'h00, 0);
    rd(1);
    chk({8'h00, rx0}, 16'h0080);
    irq_at(2, 1'b1);
    wr(8'h00, 8'h00, 8'h00, 0);
    irq_at(2, 1'b1);
    // pointer left at zero: another slave acking a read drops the line
    open_frame(7'h31, 1'b1, 1'b1);
    ioxirq_i2c_master_inst.stop();
    irq_at(10, 1'b0);
    port_pins <= 16'h0031;
    irq_at(830, 1'b1);
    rd(1);
    chk({8'h00, rx0}, 16'h0030);
    irq_at(10, 1'b0);
    // output pin moves, then is turned into an input that disagrees
    port_pins <= 16'h0030;
    irq_at(20, 1'b0);
    wr(8'h06, 8'hF1, 8'h00, 1);
    irq_at(830, 1'b1);
    // second reset in mid-run restores defaults
    srst <= 1'b1;
    tick(3);
    srst <= 1'b0;
    tick(20);
    chk(port_o, 16'hFFFF);
    chk({port_oe[14:0], irq_oe}, 16'h0000);
    chk(port_oe | hi_drv | lo_drv, 16'h0000);
    chk({15'h0, sda_oe | sda_o}, 16'h0000);
    close_out();
  end
endmodule
`default_nettype wire
